// >>> common/mfs_pkg.sv
package mfs_pkg;
  // Lock response codes
  localparam logic [2:0] LOCK_LATCH_OFF  = 3'h0;
  localparam logic [2:0] LOCK_LATCH_LS   = 3'h1;
  localparam logic [2:0] LOCK_LATCH_HS   = 3'h2;
  localparam logic [2:0] LOCK_RETRY_OFF  = 3'h3;
  localparam logic [2:0] LOCK_RETRY_LS   = 3'h4;
  localparam logic [2:0] LOCK_RETRY_HS   = 3'h5;
  localparam logic [2:0] LOCK_REPORT     = 3'h6;
  localparam logic [2:0] LOCK_DISABLED   = 3'h7;
  // Power stage commands
  localparam logic [2:0] STAGE_RUN       = 3'h0;
  localparam logic [2:0] STAGE_ALL_OFF   = 3'h1;
  localparam logic [2:0] STAGE_LOW_ON    = 3'h2;
  localparam logic [2:0] STAGE_HIGH_ON   = 3'h3;
  localparam logic [2:0] STAGE_HIZ       = 3'h4;
  // Motor control states
  localparam logic [2:0] MST_IDLE        = 3'h0;
  localparam logic [2:0] MST_PULSE_DET   = 3'h1;
  localparam logic [2:0] MST_ALIGN       = 3'h2;
  localparam logic [2:0] MST_DBL_ALIGN   = 3'h3;
  localparam logic [2:0] MST_OPEN_LOOP   = 3'h4;
  localparam logic [2:0] MST_CLOSED_LOOP = 3'h5;
  // Timing
  localparam int         CLK_HZ          = 20_000_000;
  localparam int         NOMOTOR_MS      = 500;
  localparam int         NOMOTOR_CYCLES  = (CLK_HZ / 1000) * NOMOTOR_MS;
  localparam int         MS_CYCLES       = CLK_HZ / 1000;
  // Speed floor for no-motor detection, in speed units of 0.1 Hz
  localparam logic [15:0] SPEED_FLOOR_2HZ = 16'h0014;
  // Reset values
  localparam logic       PIN_RST         = 1'b1;
  localparam logic [7:0] CAUSE_RST       = 8'h00;
endpackage

// >>> hdl/mfs_supervisor.sv
`timescale 1ns/1ps
module mfs_supervisor #(
  parameter int SW = 16,
  parameter int IW = 12,
  parameter int VW = 12,
  parameter int NOMOTOR_COUNT = mfs_pkg::NOMOTOR_CYCLES,
  parameter int MS_COUNT      = mfs_pkg::MS_CYCLES
) (
  input  wire logic          core_clk,
  input  wire logic          sys_rst,
  input  wire logic [SW-1:0] speed_est,
  input  wire logic [SW-1:0] overspeed_threshold,
  input  wire logic          overspeed_check_enable,
  input  wire logic [SW-1:0] bemf_diff,
  input  wire logic [SW-1:0] bemf_mismatch_threshold,
  input  wire logic [15:0]   bemf_mismatch_persist,
  input  wire logic          bemf_check_enable,
  input  wire logic [IW-1:0] phase_current_a,
  input  wire logic [IW-1:0] phase_current_b,
  input  wire logic [IW-1:0] phase_current_c,
  input  wire logic [IW-1:0] nomotor_current_threshold,
  input  wire logic          nomotor_check_enable,
  input  wire logic          nomotor_closedloop_disable,
  input  wire logic [2:0]    motor_state,
  input  wire logic [2:0]    lock_response_select,
  input  wire logic [15:0]   lock_retry_time,
  input  wire logic          fault_clear,
  input  wire logic          power_up_wake,
  input  wire logic          mem_read_done,
  input  wire logic [15:0]   mem_read_crc_calc,
  input  wire logic          mem_parity_error,
  input  wire logic          mem_write_done,
  input  wire logic [15:0]   mem_write_crc,
  input  wire logic          memory_fault_response,
  input  wire logic          bus_crc_enable,
  input  wire logic          bus_packet_done,
  input  wire logic          bus_crc_mismatch,
  input  wire logic          bus_crc_response,
  input  wire logic [VW-1:0] supply_level,
  input  wire logic [VW-1:0] supply_low_threshold,
  input  wire logic [VW-1:0] supply_high_threshold,
  input  wire logic [VW-1:0] supply_hysteresis,
  input  wire logic          supply_low_response,
  input  wire logic          supply_high_response,
  input  wire logic          measure_active,
  input  wire logic          ramp_timer_overflow,
  input  wire logic          ramp_current_reached,
  input  wire logic          bemf_measure_done,
  input  wire logic [SW-1:0] bemf_measured,
  input  wire logic [SW-1:0] stationary_detect_threshold,
  output logic               fault_pin_n,
  output logic [2:0]         stage_cmd,
  output logic               controller_fault,
  output logic               motor_lock_event,
  output logic               overspeed_lock,
  output logic               bemf_mismatch_lock,
  output logic               nomotor_event,
  output logic               memory_error,
  output logic               bus_crc_fault,
  output logic               supply_low_fault,
  output logic               supply_high_fault,
  output logic               measure_pulse_fault,
  output logic               measure_backemf_fault,
  output logic               mem_read_request
);

  typedef enum logic [1:0] {
    MFS_RUN     = 2'b00,
    MFS_LATCHED = 2'b01,
    MFS_RETRY   = 2'b11,
    MFS_REPORT  = 2'b10
  } mfs_lock_e;

  // Lock state
  mfs_lock_e       lock_reg, lock_next;
  logic [2:0]      lock_mode_reg, lock_mode_next;
  logic [2:0]      cause_reg, cause_next;
  logic [15:0]     retry_ms_reg, retry_ms_next;
  logic [31:0]     tick_reg, tick_next;
  logic [31:0]     persist_reg, persist_next;
  logic [31:0]     nomotor_reg, nomotor_next;
  // Other fault state
  logic            mem_err_reg, mem_err_next, mem_hiz_reg, mem_hiz_next;
  logic            crc_err_reg, crc_err_next, crc_hiz_reg, crc_hiz_next;
  logic            uv_reg, uv_next, ov_reg, ov_next;
  logic            mp_reg, mp_next, mb_reg, mb_next;
  logic [15:0]     crc_store_reg, crc_store_next;
  logic            rdreq_reg, rdreq_next;
  // Output registers
  logic            pin_n_reg, pin_n_next;
  logic [2:0]      stage_reg, stage_next;
  logic            cf_reg, cf_next, ml_reg, ml_next;

  // Cause conditions
  logic            os_hit, bemf_over, bemf_hit, nm_low, nm_allowed, nm_hit, any_lock;
  logic            lock_cond_gone, ms_tick, uv_now, ov_now;

  // Lock sources
  always_comb begin
    os_hit     = overspeed_check_enable && (speed_est > overspeed_threshold);
    bemf_over  = bemf_diff > bemf_mismatch_threshold;
    bemf_hit   = bemf_check_enable && bemf_over && (persist_reg >= 32'(bemf_mismatch_persist));
    nm_low     = (phase_current_a < nomotor_current_threshold) ||
                 (phase_current_b < nomotor_current_threshold) ||
                 (phase_current_c < nomotor_current_threshold);
    nm_allowed = nomotor_check_enable && (speed_est >= SW'(mfs_pkg::SPEED_FLOOR_2HZ)) &&
                 ((motor_state == mfs_pkg::MST_OPEN_LOOP) ||
                  (motor_state == mfs_pkg::MST_CLOSED_LOOP && !nomotor_closedloop_disable));
    nm_hit     = nm_allowed && nm_low && (nomotor_reg >= 32'(NOMOTOR_COUNT - 1));
    any_lock   = os_hit || bemf_hit || nm_hit;
    lock_cond_gone = !any_lock;
    ms_tick    = tick_reg >= 32'(MS_COUNT - 1);
    uv_now     = supply_level <= supply_low_threshold;
    ov_now     = supply_level >= supply_high_threshold;
  end

  // Lock response machine
  always_comb begin
    lock_next      = lock_reg;
    lock_mode_next = lock_mode_reg;
    cause_next     = cause_reg;
    retry_ms_next  = retry_ms_reg;
    tick_next      = ms_tick ? 32'h0 : tick_reg + 32'h1;
    persist_next   = bemf_over ? ((persist_reg == 32'hffffffff) ? persist_reg
                                                                 : persist_reg + 32'h1) : 32'h0;
    nomotor_next   = (nm_allowed && nm_low) ? ((nm_hit) ? nomotor_reg : nomotor_reg + 32'h1)
                                            : 32'h0;
    unique case (lock_reg)
      MFS_RUN: begin
        if (any_lock && lock_response_select != mfs_pkg::LOCK_DISABLED) begin
          lock_mode_next = lock_response_select;
          cause_next     = {nm_hit, bemf_hit, os_hit};
          tick_next      = 32'h0;
          retry_ms_next  = 16'h0;
          if (lock_response_select <= mfs_pkg::LOCK_LATCH_HS) begin
            lock_next = MFS_LATCHED;
          end else if (lock_response_select <= mfs_pkg::LOCK_RETRY_HS) begin
            lock_next = MFS_RETRY;
          end else begin
            lock_next = MFS_REPORT;
          end
        end
      end
      MFS_RETRY: begin
        cause_next = cause_reg | {nm_hit, bemf_hit, os_hit};
        if (any_lock) begin
          retry_ms_next = 16'h0;
          tick_next     = 32'h0;
        end else if (ms_tick) begin
          retry_ms_next = retry_ms_reg + 16'h1;
        end
        if (!any_lock && ms_tick && (retry_ms_reg + 16'h1 >= lock_retry_time)) begin
          lock_next  = MFS_RUN;
          cause_next = 3'h0;
        end
      end
      MFS_LATCHED, MFS_REPORT: begin
        cause_next = cause_reg | {nm_hit, bemf_hit, os_hit};
        if (fault_clear && lock_cond_gone) begin
          lock_next  = MFS_RUN;
          cause_next = 3'h0;
        end
      end
    endcase
  end

  // Other faults
  always_comb begin
    mem_err_next   = mem_err_reg;
    mem_hiz_next   = mem_hiz_reg;
    crc_err_next   = crc_err_reg;
    crc_hiz_next   = crc_hiz_reg;
    uv_next        = uv_reg;
    ov_next        = ov_reg;
    mp_next        = mp_reg;
    mb_next        = mb_reg;
    crc_store_next = crc_store_reg;
    rdreq_next     = power_up_wake;
    if (fault_clear) begin
      mem_err_next = 1'b0;
      mem_hiz_next = 1'b0;
      crc_err_next = 1'b0;
      crc_hiz_next = 1'b0;
      mp_next      = 1'b0;
      mb_next      = 1'b0;
      if (!uv_now) uv_next = 1'b0;
      if (!ov_now) ov_next = 1'b0;
    end
    if (mem_write_done) crc_store_next = mem_write_crc;
    if (mem_read_done && (mem_parity_error || mem_read_crc_calc != crc_store_reg)) begin
      mem_err_next = 1'b1;
      if (!memory_fault_response) mem_hiz_next = 1'b1;
    end
    if (bus_crc_enable && bus_packet_done && bus_crc_mismatch) begin
      crc_err_next = 1'b1;
      if (!bus_crc_response) crc_hiz_next = 1'b1;
    end
    if (uv_now) begin
      uv_next = 1'b1;
    end else if (supply_low_response &&
                 ({1'b0, supply_level} >
                  {1'b0, supply_low_threshold} + {1'b0, supply_hysteresis})) begin
      uv_next = 1'b0;
    end
    if (ov_now) begin
      ov_next = 1'b1;
    end else if (supply_high_response &&
                 ({1'b0, supply_level} + {1'b0, supply_hysteresis} <
                  {1'b0, supply_high_threshold})) begin
      ov_next = 1'b0;
    end
    if (measure_active && ramp_timer_overflow && !ramp_current_reached) mp_next = 1'b1;
    if (bemf_measure_done && bemf_measured < stationary_detect_threshold) mb_next = 1'b1;
  end

  // Outputs
  always_comb begin
    stage_next = mfs_pkg::STAGE_RUN;
    pin_n_next = 1'b1;
    if (lock_next == MFS_LATCHED || lock_next == MFS_RETRY) begin
      pin_n_next = 1'b0;
      unique case (lock_mode_next)
        mfs_pkg::LOCK_LATCH_LS, mfs_pkg::LOCK_RETRY_LS: stage_next = mfs_pkg::STAGE_LOW_ON;
        mfs_pkg::LOCK_LATCH_HS, mfs_pkg::LOCK_RETRY_HS: stage_next = mfs_pkg::STAGE_HIGH_ON;
        default:                                        stage_next = mfs_pkg::STAGE_ALL_OFF;
      endcase
    end
    if (mem_err_next || crc_err_next) pin_n_next = 1'b0;
    if (mem_hiz_next || crc_hiz_next || uv_next || ov_next) stage_next = mfs_pkg::STAGE_HIZ;
    ml_next = lock_next != MFS_RUN;
    cf_next = ml_next || mem_err_next || crc_err_next;
  end

  // State registers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      lock_reg      <= MFS_RUN;
      lock_mode_reg <= 3'h0;
      cause_reg     <= 3'h0;
      retry_ms_reg  <= 16'h0;
      tick_reg      <= 32'h0;
      persist_reg   <= 32'h0;
      nomotor_reg   <= 32'h0;
      mem_err_reg   <= 1'b0;
      mem_hiz_reg   <= 1'b0;
      crc_err_reg   <= 1'b0;
      crc_hiz_reg   <= 1'b0;
      uv_reg        <= 1'b0;
      ov_reg        <= 1'b0;
      mp_reg        <= 1'b0;
      mb_reg        <= 1'b0;
      crc_store_reg <= 16'h0;
      rdreq_reg     <= 1'b0;
      pin_n_reg     <= mfs_pkg::PIN_RST;
      stage_reg     <= mfs_pkg::STAGE_RUN;
      cf_reg        <= 1'b0;
      ml_reg        <= 1'b0;
    end else begin
      lock_reg      <= lock_next;
      lock_mode_reg <= lock_mode_next;
      cause_reg     <= cause_next;
      retry_ms_reg  <= retry_ms_next;
      tick_reg      <= tick_next;
      persist_reg   <= persist_next;
      nomotor_reg   <= nomotor_next;
      mem_err_reg   <= mem_err_next;
      mem_hiz_reg   <= mem_hiz_next;
      crc_err_reg   <= crc_err_next;
      crc_hiz_reg   <= crc_hiz_next;
      uv_reg        <= uv_next;
      ov_reg        <= ov_next;
      mp_reg        <= mp_next;
      mb_reg        <= mb_next;
      crc_store_reg <= crc_store_next;
      rdreq_reg     <= rdreq_next;
      pin_n_reg     <= pin_n_next;
      stage_reg     <= stage_next;
      cf_reg        <= cf_next;
      ml_reg        <= ml_next;
    end
  end

  // Port drive
  assign fault_pin_n           = pin_n_reg;
  assign stage_cmd             = stage_reg;
  assign controller_fault      = cf_reg;
  assign motor_lock_event      = ml_reg;
  assign overspeed_lock        = cause_reg[0];
  assign bemf_mismatch_lock    = cause_reg[1];
  assign nomotor_event         = cause_reg[2];
  assign memory_error          = mem_err_reg;
  assign bus_crc_fault         = crc_err_reg;
  assign supply_low_fault      = uv_reg;
  assign supply_high_fault     = ov_reg;
  assign measure_pulse_fault   = mp_reg;
  assign measure_backemf_fault = mb_reg;
  assign mem_read_request      = rdreq_reg;

endmodule

// >>> tb/mfs_mem_model.sv
`timescale 1ns/1ps
// Configuration memory that answers read requests after a fixed delay
module mfs_mem_model #(
  parameter int DLY = 3
) (
  input  wire logic        core_clk,
  input  wire logic        sys_rst,
  input  wire logic        mem_read_request,
  input  wire logic [15:0] crc_value,
  input  wire logic        bad_parity,
  output logic             mem_read_done,
  output logic [15:0]      mem_read_crc_calc,
  output logic             mem_parity_error
);
  int cnt;
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) cnt <= 0;
    else if (mem_read_request) cnt <= DLY;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  // Result lines carry junk outside the done cycle
  assign mem_read_done = (cnt == 1);
  assign mem_read_crc_calc = mem_read_done ? crc_value : ~crc_value;
  assign mem_parity_error = mem_read_done ? bad_parity : ~bad_parity;
endmodule

// >>> tb/mfs_supervisor_chk.sv
`timescale 1ns/1ps
module mfs_chk #(
  parameter int NOMOTOR_COUNT = 50,
  parameter int MS_COUNT      = 4
) (
  input wire logic        core_clk,
  input wire logic        sys_rst,
  input wire logic [15:0] speed_est,
  input wire logic [15:0] overspeed_threshold,
  input wire logic        overspeed_check_enable,
  input wire logic [2:0]  lock_response_select,
  input wire logic        fault_clear,
  input wire logic        power_up_wake,
  input wire logic        mem_read_done,
  input wire logic        mem_parity_error,
  input wire logic        bus_crc_enable,
  input wire logic        bus_packet_done,
  input wire logic        bus_crc_mismatch,
  input wire logic [11:0] supply_level,
  input wire logic [11:0] supply_low_threshold,
  input wire logic [11:0] supply_high_threshold,
  input wire logic        fault_pin_n,
  input wire logic [2:0]  stage_cmd,
  input wire logic        controller_fault,
  input wire logic        motor_lock_event,
  input wire logic        overspeed_lock,
  input wire logic        memory_error,
  input wire logic        bus_crc_fault,
  input wire logic        supply_low_fault,
  input wire logic        supply_high_fault,
  input wire logic        mem_read_request
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  logic other_flt;
  // Faults that override the lock stage command or the fault pin
  assign other_flt = memory_error | bus_crc_fault | supply_low_fault | supply_high_fault;
  // Stage expected for each lock response
  function automatic logic [2:0] stage_of(input logic [2:0] m);
    case (m)
      3'h0, 3'h3: stage_of = mfs_pkg::STAGE_ALL_OFF;
      3'h1, 3'h4: stage_of = mfs_pkg::STAGE_LOW_ON;
      3'h2, 3'h5: stage_of = mfs_pkg::STAGE_HIGH_ON;
      default: stage_of = mfs_pkg::STAGE_RUN;
    endcase
  endfunction
  sequence s_lock_out;
    motor_lock_event && controller_fault && overspeed_lock;
  endsequence
  sequence s_fast;
    overspeed_check_enable && speed_est > overspeed_threshold;
  endsequence
  chk_overspeed_lock: assert property (
    s_fast ##0 lock_response_select != mfs_pkg::LOCK_DISABLED |=> s_lock_out)
    else $error("overspeed did not raise lock");
  chk_lock_stage: assert property (
    motor_lock_event && !other_flt |-> stage_cmd == stage_of(lock_response_select)
    && fault_pin_n == (lock_response_select == mfs_pkg::LOCK_REPORT))
    else $error("lock stage or pin wrong");
  chk_latch_hold: assert property (
    motor_lock_event && !fault_clear && lock_response_select inside {3'h0, 3'h1, 3'h2, 3'h6}
    |=> motor_lock_event) else $error("latched lock dropped without clear");
  chk_disabled_quiet: assert property (
    lock_response_select == mfs_pkg::LOCK_DISABLED && !motor_lock_event |=> !motor_lock_event)
    else $error("disabled mode reported lock");
  chk_mem_parity: assert property (
    mem_read_done && mem_parity_error |=> memory_error && controller_fault && !fault_pin_n)
    else $error("parity error not flagged");
  chk_read_issue: assert property (
    power_up_wake |=> mem_read_request) else $error("no read after wake");
  chk_bus_crc: assert property (
    bus_crc_enable && bus_packet_done && bus_crc_mismatch |=> bus_crc_fault && !fault_pin_n)
    else $error("bus crc fault missed");
  chk_supply_low: assert property (
    supply_level <= supply_low_threshold |=> supply_low_fault && stage_cmd == mfs_pkg::STAGE_HIZ)
    else $error("undervoltage not handled");
  chk_supply_high: assert property (
    supply_level >= supply_high_threshold |=> supply_high_fault && stage_cmd == mfs_pkg::STAGE_HIZ)
    else $error("overvoltage not handled");
endmodule
bind mfs_supervisor mfs_chk #(.NOMOTOR_COUNT(NOMOTOR_COUNT), .MS_COUNT(MS_COUNT)) chk_u (.*);

// >>> tb/testbench.sv
`timescale 1ns/1ps
`define CHK(a,b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, (a), (b)); end end
module testbench;
  logic core_clk, sys_rst, overspeed_check_enable, bemf_check_enable, nomotor_check_enable;
  logic nomotor_closedloop_disable, fault_clear, power_up_wake, mem_write_done, bad_parity;
  logic memory_fault_response, bus_crc_enable, bus_packet_done, bus_crc_mismatch;
  logic bus_crc_response, supply_low_response, supply_high_response, measure_active;
  logic ramp_timer_overflow, ramp_current_reached, bemf_measure_done, mem_read_done;
  logic fault_pin_n, controller_fault, motor_lock_event, overspeed_lock, bemf_mismatch_lock;
  logic nomotor_event, memory_error, bus_crc_fault, supply_low_fault, supply_high_fault;
  logic measure_pulse_fault, measure_backemf_fault, mem_read_request, mem_parity_error;
  logic [15:0] speed_est, overspeed_threshold, bemf_diff, bemf_mismatch_threshold, crc_value;
  logic [15:0] bemf_mismatch_persist, lock_retry_time, mem_write_crc, mem_read_crc_calc;
  logic [15:0] bemf_measured, stationary_detect_threshold;
  logic [11:0] phase_current_a, phase_current_b, phase_current_c, nomotor_current_threshold;
  logic [11:0] supply_level, supply_low_threshold, supply_high_threshold, supply_hysteresis;
  logic [2:0]  motor_state, lock_response_select, stage_cmd;
  logic [2:0]  st [8];
  int          mismatches, checks_done, i;
  mfs_supervisor #(.NOMOTOR_COUNT(50), .MS_COUNT(4)) dut_u (.*);
  mfs_mem_model mem_u (.*);
  // Free-running clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  task automatic cy(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic clr();
    fault_clear = 1'b1;
    cy(1);
    fault_clear = 1'b0;
  endtask
  task automatic wake();
    power_up_wake = 1'b1;
    cy(1);
    power_up_wake = 1'b0;
    `CHK(mem_read_request, 1'b1)
    cy(5);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    for (i = 0; i < lim && s !== v; i++) cy(1);
    if (s !== v) begin
      mismatches++;
      give_verdict();
    end
  endtask
  task automatic vm(input logic hi, input logic r, ref logic f);
    {supply_low_response, supply_high_response} = {r, r};
    supply_level = hi ? 12'hc10 : 12'h3f0;
    cy(1);
    `CHK(f, 1'b1)
    `CHK(stage_cmd, mfs_pkg::STAGE_HIZ)
    supply_level = hi ? 12'hbf0 : 12'h420;
    cy(2);
    `CHK(f, 1'b1)
    supply_level = 12'h800;
    cy(2);
    `CHK(f, !r)
    clr();
    `CHK(f, 1'b0)
  endtask
  // Main sequence
  initial begin
    {nomotor_closedloop_disable, fault_clear, power_up_wake, mem_write_done, bad_parity,
     memory_fault_response, bus_crc_enable, bus_packet_done, bus_crc_mismatch, bus_crc_response,
     supply_low_response, supply_high_response, measure_active, ramp_timer_overflow,
     ramp_current_reached, bemf_measure_done, bemf_diff, mem_write_crc, crc_value,
     bemf_measured, motor_state, lock_response_select} = '0;
    {overspeed_check_enable, bemf_check_enable, nomotor_check_enable} = 3'h7;
    {mismatches, checks_done} = '0;
    st = '{mfs_pkg::STAGE_ALL_OFF, mfs_pkg::STAGE_LOW_ON, mfs_pkg::STAGE_HIGH_ON,
           mfs_pkg::STAGE_ALL_OFF, mfs_pkg::STAGE_LOW_ON, mfs_pkg::STAGE_HIGH_ON,
           mfs_pkg::STAGE_RUN, mfs_pkg::STAGE_RUN};
    {speed_est, overspeed_threshold, lock_retry_time} = {16'h0080, 16'h0100, 16'h0002};
    {bemf_mismatch_threshold, bemf_mismatch_persist} = {16'h0040, 16'h0005};
    stationary_detect_threshold = 16'h0030;
    {phase_current_a, phase_current_b, phase_current_c} = {3{12'h200}};
    {nomotor_current_threshold, supply_level} = {12'h010, 12'h800};
    {supply_low_threshold, supply_high_threshold, supply_hysteresis} = {12'h400, 12'hc00, 12'h040};
    sys_rst = 1'b1;
    cy(16);
    sys_rst = 1'b0;
    `CHK(fault_pin_n, mfs_pkg::PIN_RST)
    // Every lock response, with clear refused while the cause stays in the latched and report modes
    for (int m = 0; m < 8; m++) begin
      lock_response_select = m[2:0];
      speed_est = 16'h0200;
      cy(1);
      `CHK(motor_lock_event, m != 7)
      `CHK(stage_cmd, st[m])
      `CHK(fault_pin_n, m > 5)
      if (m < 3 || m == 6) begin
        clr();
        `CHK(motor_lock_event, 1'b1)
        speed_est = 16'h0080;
        cy(2);
        `CHK(controller_fault, 1'b1)
        clr();
      end else if (m < 6) begin
        speed_est = 16'h0080;
        cy(4);
        speed_est = 16'h0200;
        cy(1);
        speed_est = 16'h0080;
        cy(6);
        `CHK(motor_lock_event, 1'b1)
        wait_lvl(motor_lock_event, 1'b0, 20);
      end
      speed_est = 16'h0080;
      cy(1);
      `CHK({motor_lock_event, fault_pin_n, stage_cmd}, {2'b01, mfs_pkg::STAGE_RUN})
    end
    $display("lock response test done");
    // Back-EMF persistence and per-cause enable, report mode
    lock_response_select = mfs_pkg::LOCK_REPORT;
    overspeed_check_enable = 1'b0;
    speed_est = 16'h0200;
    bemf_diff = 16'h0080;
    cy(3);
    bemf_diff = 16'h0000;
    cy(2);
    `CHK(motor_lock_event, 1'b0)
    bemf_diff = 16'h0080;
    cy(8);
    `CHK(bemf_mismatch_lock, 1'b1)
    {bemf_diff, speed_est, overspeed_check_enable} = {16'h0000, 16'h0080, 1'b1};
    clr();
    `CHK(motor_lock_event, 1'b0)
    $display("bemf test done");
    // No-motor gating by state, speed floor and closed-loop disable
    phase_current_b = 12'h008;
    for (int s = 0; s < 4; s++) begin
      motor_state = s[2:0];
      cy(60);
      `CHK(nomotor_event, 1'b0)
    end
    {motor_state, speed_est} = {mfs_pkg::MST_OPEN_LOOP, 16'h000a};
    cy(60);
    `CHK(nomotor_event, 1'b0)
    {motor_state, speed_est} = {mfs_pkg::MST_CLOSED_LOOP, 16'h0080};
    nomotor_closedloop_disable = 1'b1;
    cy(60);
    `CHK(nomotor_event, 1'b0)
    nomotor_closedloop_disable = 1'b0;
    cy(45);
    `CHK(nomotor_event, 1'b0)
    cy(10);
    `CHK(nomotor_event, 1'b1)
    phase_current_b = 12'h200;
    clr();
    `CHK(motor_lock_event, 1'b0)
    $display("no-motor test done");
    // Memory read checks, write while faulted, report mode
    wake();
    `CHK(memory_error, 1'b0)
    crc_value = 16'h1234;
    wake();
    `CHK({memory_error, fault_pin_n, stage_cmd}, {2'b10, mfs_pkg::STAGE_HIZ})
    {mem_write_crc, mem_write_done} = {16'h1234, 1'b1};
    cy(1);
    mem_write_done = 1'b0;
    clr();
    `CHK({memory_error, fault_pin_n}, 2'b01)
    wake();
    `CHK(memory_error, 1'b0)
    {bad_parity, memory_fault_response} = 2'b11;
    wake();
    `CHK({memory_error, stage_cmd}, {1'b1, mfs_pkg::STAGE_RUN})
    bad_parity = 1'b0;
    clr();
    $display("memory test done");
    // Bus CRC check off, then both responses; one packet each, cleared after
    bus_crc_mismatch = 1'b1;
    for (int r = 0; r < 3; r++) begin
      {bus_crc_enable, bus_crc_response, bus_packet_done} = {r > 0, r == 2, 1'b1};
      cy(1);
      bus_packet_done = 1'b0;
      `CHK(bus_crc_fault, r > 0)
      `CHK(fault_pin_n, r == 0)
      `CHK(stage_cmd, r == 1 ? mfs_pkg::STAGE_HIZ : mfs_pkg::STAGE_RUN)
      clr();
      `CHK({bus_crc_fault, fault_pin_n}, 2'b01)
    end
    bus_crc_mismatch = 1'b0;
    $display("bus crc test done");
    for (int r = 0; r < 2; r++) begin
      vm(1'b0, r[0], supply_low_fault);
      vm(1'b1, r[0], supply_high_fault);
    end
    $display("supply test done");
    // Measurement faults
    {measure_active, ramp_timer_overflow, ramp_current_reached} = 3'h7;
    cy(1);
    `CHK(measure_pulse_fault, 1'b0)
    ramp_current_reached = 1'b0;
    {bemf_measure_done, bemf_measured} = {1'b1, 16'h0010};
    cy(1);
    {measure_active, ramp_timer_overflow, bemf_measure_done} = 3'h0;
    `CHK({measure_pulse_fault, measure_backemf_fault}, 2'b11)
    clr();
    `CHK({measure_pulse_fault, measure_backemf_fault}, 2'b00)
    $display("measure test done");
    give_verdict();
  end
endmodule
